// file: logic/bit_addr_decode.sv
// Splits a direct bit address into its storage byte and bit position
`timescale 1ns/1ps
module bit_addr_decode (
  input wire logic [7:0] bit_addr, // Direct bit address
  output logic ram_space, // High for lower RAM bit page
  output logic [7:0] byte_addr, // Byte holding the bit
  output logic [2:0] pos // Bit position in that byte
);
  import bit_branch_pkg::*;
  wire logic in_ram = bit_addr < BIT_SPACE_SPLIT; // [RULE1]
  wire logic [7:0] ram_byte = RAM_BIT_BASE + {4'h0, bit_addr[6:3]}; // [RULE2]
  wire logic [7:0] sfr_byte = bit_addr & SFR_ALIGN_MASK; // [RULE22]
  assign ram_space = in_ram;
  assign byte_addr = in_ram ? ram_byte : sfr_byte;
  assign pos = bit_addr[BIT_POS_W-1:0];
endmodule

// file: logic/bit_branch_pkg.sv
// Package with opcode classes, bit-address layout and shared carrier types for the bit and branch unit
package bit_branch_pkg;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [7:0] BIT_SPACE_SPLIT = 8'h80;
  localparam logic [7:0] BIT_SPACE_LAST = 8'hFF;
  localparam int RAM_BIT_COUNT = 128;
  localparam int SFR_BIT_COUNT = 128;
  localparam logic [7:0] RAM_BIT_BASE = 8'h20;
  localparam int BIT_POS_W = 3;
  localparam logic [7:0] SFR_ALIGN_MASK = 8'hF8;
  localparam logic [7:0] PSW_ADDR = 8'hD0;
  localparam int CARRY_POS = 7;
  localparam logic [ADDR_W-1:0] PAGE_HIGH_MASK = 16'hF800;
  localparam logic [ADDR_W-1:0] PAGE_LOW_MASK = 16'h07FF;
  localparam logic [ADDR_W-1:0] LEN_SHORT = 16'h0002;
  localparam logic [ADDR_W-1:0] LEN_LONG = 16'h0003;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  typedef enum logic [4:0] {
    OP_NOP, OP_MOV_C_BIT, OP_MOV_BIT_C, OP_CLR_C, OP_CLR_BIT, OP_SET_C, OP_SET_BIT,
    OP_CPL_C, OP_CPL_BIT, OP_AND_C, OP_ANDN_C, OP_OR_C, OP_ORN_C,
    OP_JC, OP_JNC, OP_JB, OP_JNB, OP_JBC,
    OP_SHORT_RELATIVE_JUMP, OP_LONG_ABSOLUTE_JUMP, OP_PAGE_ABSOLUTE_JUMP, OP_JMP_IDX, OP_LONG_SUBROUTINE_CALL, OP_PAGE_SUBROUTINE_CALL, OP_RET, OP_INTERRUPT_RETURN,
    OP_JZ, OP_JNZ, OP_DECREMENT_BRANCH_NONZERO, OP_COMPARE_BRANCH_UNEQUAL
  } op_type;

  typedef struct packed {
    op_type op;
    logic [ADDR_W-1:0] pc;
    logic [7:0] bit_addr;
    logic [7:0] rel;
    logic [ADDR_W-1:0] target16;
    logic [10:0] target11;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic [7:0] acc;
    logic [ADDR_W-1:0] data_pointer16;
    logic [ADDR_W-1:0] ret_addr;
    logic bit_val;
  } instr_type;

  typedef struct packed {
    logic valid;
    logic ram_space;
    logic [7:0] byte_addr;
    logic [BIT_POS_W-1:0] pos;
    logic value;
  } bit_wr_type;
endpackage

// file: logic/bit_branch_unit.sv
// Boolean processor and program-flow execution unit of the 8-bit core
// Summary of operation
// [RULE1] Bit addresses below 80h hit lower RAM, 80h to FFh hit register space.
// [RULE2] 128 RAM bits and up to 128 register bits are addressable.
// [RULE3] Bit operands come only from a direct address byte.
// [RULE4] Carry is the bit accumulator and also sits at its own bit address.
// [RULE5] Move, clear, set, complement, AND and OR with carry are supported.
// [RULE6] No bit exclusive-OR exists; software builds it.
// [RULE7] Jumps on carry set, carry clear, bit set and bit clear.
// [RULE8] Jump-bit-set-and-clear branches on one and clears the bit.
// [RULE9] Relative target is next-instruction address plus signed offset byte.
// [RULE10] Short relative jump is two bytes long.
// [RULE11] Long jump is three bytes and loads a full 16-bit target.
// [RULE12] Page jump swaps the low 11 PC bits, keeps the high 5.
// [RULE13] Indexed jump goes to data pointer plus accumulator.
// [RULE14] Long call reaches anywhere with a 16-bit target.
// [RULE15] Page call uses 11 bits within the 2K block of the next instruction.
// [RULE16] Return resumes after the originating call.
// [RULE17] Interrupt return also signals end of service to interrupt logic.
// [RULE18] Zero tests look at the accumulator; no zero flag exists.
// [RULE19] Decrement-and-branch jumps when the decremented value is nonzero.
// [RULE20] Compare-and-branch jumps only when operands differ.
// [RULE21] Compare sets carry when first is unsigned-less than second.
// [RULE22] Register bit selects byte with low three bits cleared, position from them.
`timescale 1ns/1ps
module bit_branch_unit #(
  parameter int PC_W = 16 // Program counter width
) (
  input wire logic clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic exec_valid, // One-cycle strobe: execute instr
  input wire bit_branch_pkg::instr_type instr, // Decoded instruction and operands
  input wire logic carry_in, // Current carry from status word
  output logic done_reg, // Pulse: results below valid
  output logic [PC_W-1:0] pc_reg, // Next program counter
  output logic taken_reg, // Branch was taken
  output logic carry_we_reg, // Carry write enable
  output logic carry_reg, // New carry value
  output bit_branch_pkg::bit_wr_type bit_wr_reg, // Bit write request
  output logic byte_we_reg, // Byte operand write enable
  output logic [7:0] byte_reg, // New byte value (decrement result)
  output logic push_reg, // Push return address
  output logic [PC_W-1:0] push_addr_reg, // Return address to push
  output logic pop_reg, // Pop return address
  output logic irq_done_reg // Pulse: interrupt service finished
);
  import bit_branch_pkg::*;

  initial begin
    if (PC_W != ADDR_W) $error("PC_W must equal ADDR_W");
  end

  op_type op;
  assign op = instr.op;

  wire logic ram_sp;
  wire logic [7:0] byte_a;
  wire logic [2:0] pos;
  // Bit operand always arrives as a direct address; no register indirection exists
  bit_addr_decode u_dec ( // [RULE3]
    .bit_addr(instr.bit_addr),
    .ram_space(ram_sp),
    .byte_addr(byte_a),
    .pos(pos)
  );

  // Carry is also a bit of the status word, so the bit path must read the live carry
  wire logic is_carry_bit = (byte_a == PSW_ADDR) && (pos == 3'(CARRY_POS)); // [RULE4]
  wire logic bv = is_carry_bit ? carry_in : instr.bit_val;

  wire logic [PC_W-1:0] len = (op == OP_LONG_ABSOLUTE_JUMP || op == OP_LONG_SUBROUTINE_CALL || op == OP_COMPARE_BRANCH_UNEQUAL || op == OP_JB ||
                               op == OP_JNB || op == OP_JBC) ? LEN_LONG : LEN_SHORT; // [RULE10] [RULE11]
  wire logic [PC_W-1:0] next_pc = instr.pc + len;
  wire logic [PC_W-1:0] rel_tgt = next_pc + {{8{instr.rel[7]}}, instr.rel}; // [RULE9]
  wire logic [PC_W-1:0] page_tgt = (next_pc & PAGE_HIGH_MASK) | {5'h00, instr.target11}; // [RULE12] [RULE15]
  wire logic [PC_W-1:0] idx_tgt = instr.data_pointer16 + {8'h00, instr.acc}; // [RULE13]
  wire logic [7:0] dec_val = instr.opnd_a - ONE_BYTE;

  // Bit logic into carry; no exclusive-OR class exists in op_type [RULE6]
  logic c_we;
  logic c_val;
  always_comb begin
    c_we = 1'b1;
    case (op)
      OP_MOV_C_BIT: c_val = bv; // [RULE5]
      OP_CLR_C: c_val = 1'b0;
      OP_SET_C: c_val = 1'b1;
      OP_CPL_C: c_val = ~carry_in;
      OP_AND_C: c_val = carry_in & bv;
      OP_ANDN_C: c_val = carry_in & ~bv;
      OP_OR_C: c_val = carry_in | bv;
      OP_ORN_C: c_val = carry_in | ~bv;
      OP_COMPARE_BRANCH_UNEQUAL: c_val = instr.opnd_a < instr.opnd_b; // [RULE21]
      default: begin
        c_we = 1'b0;
        c_val = carry_in;
      end
    endcase
  end

  logic b_we;
  logic b_val;
  always_comb begin
    b_we = 1'b1;
    case (op)
      OP_MOV_BIT_C: b_val = carry_in; // [RULE5]
      OP_CLR_BIT: b_val = 1'b0;
      OP_SET_BIT: b_val = 1'b1;
      OP_CPL_BIT: b_val = ~bv;
      OP_JBC: begin
        b_we = bv; // [RULE8]
        b_val = 1'b0;
      end
      default: begin
        b_we = 1'b0;
        b_val = 1'b0;
      end
    endcase
  end

  logic tk;
  logic [PC_W-1:0] tgt;
  always_comb begin
    tk = 1'b0;
    tgt = next_pc;
    case (op)
      OP_JC: tk = carry_in; // [RULE7]
      OP_JNC: tk = ~carry_in;
      OP_JB: tk = bv;
      OP_JNB: tk = ~bv;
      OP_JBC: tk = bv; // [RULE8]
      OP_JZ: tk = (instr.acc == ZERO_BYTE); // [RULE18]
      OP_JNZ: tk = (instr.acc != ZERO_BYTE);
      OP_DECREMENT_BRANCH_NONZERO: tk = (dec_val != ZERO_BYTE); // [RULE19]
      OP_COMPARE_BRANCH_UNEQUAL: tk = (instr.opnd_a != instr.opnd_b); // [RULE20]
      OP_SHORT_RELATIVE_JUMP: tk = 1'b1; // [RULE10]
      OP_LONG_ABSOLUTE_JUMP: begin
        tk = 1'b1;
        tgt = instr.target16; // [RULE11]
      end
      OP_LONG_SUBROUTINE_CALL: begin
        tk = 1'b1;
        tgt = instr.target16; // [RULE14]
      end
      OP_PAGE_ABSOLUTE_JUMP, OP_PAGE_SUBROUTINE_CALL: begin
        tk = 1'b1;
        tgt = page_tgt; // [RULE12] [RULE15]
      end
      OP_JMP_IDX: begin
        tk = 1'b1;
        tgt = idx_tgt; // [RULE13]
      end
      OP_RET, OP_INTERRUPT_RETURN: begin
        tk = 1'b1;
        tgt = instr.ret_addr; // [RULE16]
      end
      default: tk = 1'b0;
    endcase
    if (tk && (op == OP_JC || op == OP_JNC || op == OP_JB || op == OP_JNB || op == OP_JBC ||
               op == OP_JZ || op == OP_JNZ || op == OP_DECREMENT_BRANCH_NONZERO || op == OP_COMPARE_BRANCH_UNEQUAL || op == OP_SHORT_RELATIVE_JUMP)) begin
      tgt = rel_tgt; // [RULE9]
    end
  end

  wire logic is_call = (op == OP_LONG_SUBROUTINE_CALL) || (op == OP_PAGE_SUBROUTINE_CALL);
  wire logic is_ret = (op == OP_RET) || (op == OP_INTERRUPT_RETURN);
  wire logic go = ce && exec_valid;

  bit_wr_type bw_next;
  assign bw_next = '{valid: b_we, ram_space: ram_sp, byte_addr: byte_a, pos: pos, value: b_val};

  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg <= 1'b0;
      pc_reg <= '0;
      taken_reg <= 1'b0;
      carry_we_reg <= 1'b0;
      carry_reg <= 1'b0;
      bit_wr_reg <= '0;
      byte_we_reg <= 1'b0;
      byte_reg <= ZERO_BYTE;
      push_reg <= 1'b0;
      push_addr_reg <= '0;
      pop_reg <= 1'b0;
      irq_done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= exec_valid;
      taken_reg <= exec_valid && tk;
      carry_we_reg <= exec_valid && c_we;
      bit_wr_reg <= exec_valid ? bw_next : '0;
      byte_we_reg <= exec_valid && (op == OP_DECREMENT_BRANCH_NONZERO);
      push_reg <= exec_valid && is_call;
      pop_reg <= exec_valid && is_ret;
      irq_done_reg <= exec_valid && (op == OP_INTERRUPT_RETURN); // [RULE17]
      if (exec_valid) begin
        pc_reg <= tk ? tgt : next_pc;
        carry_reg <= c_val;
        byte_reg <= dec_val;
        push_addr_reg <= next_pc; // [RULE16]
      end
    end
  end

  a_jbc_clears_bit: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    (go && op == OP_JBC && bv) |=> (taken_reg && bit_wr_reg.valid && !bit_wr_reg.value))
    else $error("bit-set-and-clear did not clear taken bit");
  a_jbc_no_branch: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    (go && op == OP_JBC && !bv) |=> (!taken_reg && !bit_wr_reg.valid))
    else $error("bit-set-and-clear acted on zero bit");
  a_rel_target: assert property (@(posedge clk) disable iff (reset) // [RULE9]
    (go && op == OP_SHORT_RELATIVE_JUMP) |=> pc_reg == $past(instr.pc) + 16'h0002 + {{8{$past(instr.rel[7])}}, $past(instr.rel)})
    else $error("short jump target wrong");
  a_page_keeps_high: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    (go && op == OP_PAGE_ABSOLUTE_JUMP) |=> (pc_reg[15:11] == $past(next_pc[15:11]) && pc_reg[10:0] == $past(instr.target11)))
    else $error("page jump altered high bits");
  a_idx_target: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    (go && op == OP_JMP_IDX) |=> pc_reg == $past(instr.data_pointer16) + {8'h00, $past(instr.acc)})
    else $error("indexed jump target wrong");
  a_interrupt_return_signals: assert property (@(posedge clk) disable iff (reset) // [RULE17]
    (go && op == OP_INTERRUPT_RETURN) |=> (irq_done_reg && pop_reg) ##1 (!irq_done_reg || !ce || $past(exec_valid)))
    else $error("interrupt return signalling wrong");
  a_decrement_branch_nonzero_branch: assert property (@(posedge clk) disable iff (reset) // [RULE19]
    (go && op == OP_DECREMENT_BRANCH_NONZERO) |=> (taken_reg == (byte_reg != 8'h00)) && byte_we_reg)
    else $error("decrement branch decision wrong");
  a_compare_branch_unequal_carry: assert property (@(posedge clk) disable iff (reset) // [RULE21]
    (go && op == OP_COMPARE_BRANCH_UNEQUAL) |=> (carry_we_reg && carry_reg == ($past(instr.opnd_a) < $past(instr.opnd_b))
      && taken_reg == ($past(instr.opnd_a) != $past(instr.opnd_b))))
    else $error("compare carry or branch wrong");
  a_jz_acc: assert property (@(posedge clk) disable iff (reset) // [RULE18]
    (go && op == OP_JZ) |=> taken_reg == ($past(instr.acc) == 8'h00))
    else $error("zero jump ignored accumulator");
endmodule

// file: tb/bit_branch_unit_tb.sv
// Self-checking testbench for the bit and branch unit
`timescale 1ns/1ps
module bit_branch_unit_tb;
  import bit_branch_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic exec_valid = 1'b0;
  logic ce = 1'b1;
  logic carry_in = 1'b0;
  instr_type ins = '0;
  logic done_reg, taken_reg, carry_we_reg, carry_reg, byte_we_reg, push_reg, pop_reg, irq_done_reg;
  logic [15:0] pc_reg, push_addr_reg;
  logic [7:0] byte_reg;
  bit_wr_type bit_wr_reg;
  int err_count = 0;
  int check_count = 0;

  always #2 clk = ~clk;

  bit_branch_unit #(.PC_W(16)) DUT (.clk(clk), .reset(reset), .ce(ce), .exec_valid(exec_valid), .instr(ins),
    .carry_in(carry_in), .done_reg(done_reg), .pc_reg(pc_reg), .taken_reg(taken_reg), .carry_we_reg(carry_we_reg),
    .carry_reg(carry_reg), .bit_wr_reg(bit_wr_reg), .byte_we_reg(byte_we_reg), .byte_reg(byte_reg),
    .push_reg(push_reg), .push_addr_reg(push_addr_reg), .pop_reg(pop_reg), .irq_done_reg(irq_done_reg));

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task fail(input string m);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task chk1(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask

  task chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask

  task chk16(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask

  // Entered on a falling edge; results are due one rising edge after the strobe.
  // The strobe stays high between calls so back-to-back instructions never toggle it twice in one step.
  task go(input op_type op, input logic [15:0] pc);
    int n;
    ins.op = op;
    ins.pc = pc;
    exec_valid = 1'b1;
    @(negedge clk);
    n = 0;
    while (done_reg !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      fail("no completion");
      end_sim;
    end
  endtask

  // Negative offset so a wrong sign extension shows up
  task br(input op_type op, input logic tk, input logic [15:0] len);
    ins.rel = 8'hF0;
    go(op, 16'h0400);
    chk1(taken_reg, tk, "taken");
    chk16(pc_reg, 16'h0400 + len + (tk ? 16'hFFF0 : 16'h0000), "branch pc");
  endtask

  task uj(input op_type op, input logic [15:0] pc, input logic [15:0] e);
    go(op, pc);
    chk1(taken_reg, 1'b1, "jump taken");
    chk16(pc_reg, e, "jump pc");
  endtask

  task t_jumps;
    ins.rel = 8'hFE;
    uj(OP_SHORT_RELATIVE_JUMP, 16'h0100, 16'h0100);
    ins.rel = 8'h7F;
    uj(OP_SHORT_RELATIVE_JUMP, 16'h1000, 16'h1081);
    ins.rel = 8'h80;
    uj(OP_SHORT_RELATIVE_JUMP, 16'h1000, 16'h0F82);
    ins.target16 = 16'hBEEF;
    uj(OP_LONG_ABSOLUTE_JUMP, 16'h0010, 16'hBEEF);
    ins.target11 = 11'h123;
    uj(OP_PAGE_ABSOLUTE_JUMP, 16'h27FE, 16'h2923);
    ins.data_pointer16 = 16'hFFF0;
    ins.acc = 8'h20;
    uj(OP_JMP_IDX, 16'h0500, 16'h0010);
  endtask

  task t_calls;
    ins.target16 = 16'h8000;
    uj(OP_LONG_SUBROUTINE_CALL, 16'h3000, 16'h8000);
    chk1(push_reg, 1'b1, "push");
    chk16(push_addr_reg, 16'h3003, "return point");
    ins.target11 = 11'h005;
    uj(OP_PAGE_SUBROUTINE_CALL, 16'h37FE, 16'h3805);
    chk16(push_addr_reg, 16'h3800, "return point");
    ins.ret_addr = 16'h3003;
    uj(OP_RET, 16'h8010, 16'h3003);
    chk1(pop_reg, 1'b1, "pop");
    chk1(irq_done_reg, 1'b0, "plain return");
    uj(OP_INTERRUPT_RETURN, 16'h8020, 16'h3003);
    chk1(irq_done_reg, 1'b1, "service end");
  endtask

  task t_carry;
    op_type ops[8] = '{OP_MOV_C_BIT, OP_CLR_C, OP_SET_C, OP_CPL_C, OP_AND_C, OP_ANDN_C, OP_OR_C, OP_ORN_C};
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        carry_in = k[1];
        ins.bit_val = k[0];
        ins.bit_addr = 8'h30;
        go(ops[i], 16'h0200);
        e = {k[1], k[0], 1'b0, 1'b1, ~k[1], k[1] & k[0], k[1] & ~k[0], k[1] | k[0]};
        chk1(carry_we_reg, 1'b1, "carry write");
        chk1(carry_reg, (i == 7) ? (k[1] | ~k[0]) : e[6 - i], "carry value");
      end
    end
    ins.bit_addr = PSW_ADDR + 8'h07;
    carry_in = 1'b1;
    ins.bit_val = 1'b0;
    go(OP_MOV_C_BIT, 16'h0200);
    chk1(carry_reg, 1'b1, "carry by address");
  endtask

  task t_bits;
    op_type ops[4] = '{OP_SET_BIT, OP_CLR_BIT, OP_CPL_BIT, OP_MOV_BIT_C};
    logic [7:0] adr[4] = '{8'h0A, 8'h7F, 8'h80, 8'h93};
    logic [7:0] a;
    logic ram;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        a = adr[j];
        ram = (a < BIT_SPACE_SPLIT);
        carry_in = j[0];
        ins.bit_val = ~j[1];
        ins.bit_addr = a;
        go(ops[i], 16'h0300);
        chk1(bit_wr_reg.valid, 1'b1, "bit write");
        chk1(bit_wr_reg.value, (i == 0) | (i == 2 && j[1]) | (i == 3 && j[0]), "bit value");
        chk1(bit_wr_reg.ram_space, ram, "space");
        chk8(bit_wr_reg.byte_addr, ram ? RAM_BIT_BASE + {4'h0, a[6:3]} : a & SFR_ALIGN_MASK, "byte");
        chk8({5'h00, bit_wr_reg.pos}, {5'h00, a[2:0]}, "position");
      end
    end
  endtask

  task t_cond;
    logic [7:0] ca[3] = '{8'h05, 8'h06, 8'hFF};
    logic [7:0] cb[3] = '{8'h06, 8'h06, 8'h00};
    for (int k = 0; k < 2; k++) begin
      carry_in = k[0];
      ins.bit_val = k[0];
      ins.bit_addr = 8'h25;
      br(OP_JC, k[0], 16'h0002);
      br(OP_JNC, ~k[0], 16'h0002);
      br(OP_JB, k[0], 16'h0003);
      br(OP_JNB, ~k[0], 16'h0003);
      br(OP_JBC, k[0], 16'h0003);
      chk1(bit_wr_reg.valid, k[0], "test and clear");
      if (k == 1) chk1(bit_wr_reg.value, 1'b0, "cleared");
      ins.acc = k[0] ? 8'h80 : 8'h00;
      br(OP_JZ, ~k[0], 16'h0002);
      br(OP_JNZ, k[0], 16'h0002);
    end
    ins.opnd_a = 8'h01;
    br(OP_DECREMENT_BRANCH_NONZERO, 1'b0, 16'h0002);
    chk8(byte_reg, 8'h00, "decrement");
    ins.opnd_a = 8'h00;
    br(OP_DECREMENT_BRANCH_NONZERO, 1'b1, 16'h0002);
    chk1(byte_we_reg, 1'b1, "byte write");
    chk8(byte_reg, 8'hFF, "decrement");
    for (int j = 0; j < 3; j++) begin
      ins.opnd_a = ca[j];
      ins.opnd_b = cb[j];
      carry_in = ~(ca[j] < cb[j]);
      br(OP_COMPARE_BRANCH_UNEQUAL, ca[j] != cb[j], 16'h0003);
      chk1(carry_reg, ca[j] < cb[j], "compare carry");
    end
  endtask

  // Clock enable low must hold every output, pulses included
  task t_freeze;
    ins.rel = 8'h10;
    uj(OP_SHORT_RELATIVE_JUMP, 16'h0600, 16'h0612);
    ce = 1'b0;
    ins.pc = 16'h0700;
    repeat (2) @(negedge clk);
    chk16(pc_reg, 16'h0612, "frozen pc");
    chk1(done_reg, 1'b1, "frozen pulse");
    ce = 1'b1;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    chk1(done_reg, 1'b0, "idle after reset");
    t_jumps;
    t_calls;
    t_carry;
    t_bits;
    t_cond;
    t_freeze;
    exec_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk1(done_reg, 1'b0, "single pulse");
    end_sim;
  end
endmodule
